// >>> chan_trim_regs.svh
// Offsets, fields, reset values and codes of the channel trim bank.
`ifndef CHAN_TRIM_REGS_SVH
`define CHAN_TRIM_REGS_SVH

// ----------------------------------------------------------------------
// Offsets on page zero
// ----------------------------------------------------------------------
`define CT_PAGE_ZERO 8'h00
`define CT_OFS_CH4_ANALOG_GAIN 8'h4C
`define CT_OFS_CH4_VOLUME 8'h4D
`define CT_OFS_CH4_ANALOG_GAIN_CODE_TRIM 8'h4E
`define CT_OFS_CH4_PHASE_TRIM 8'h4F
`define CT_OFS_CH5_VOLUME 8'h52
`define CT_OFS_CH5_GAIN_TRIM 8'h53

// ----------------------------------------------------------------------
// Reset values and field masks
// ----------------------------------------------------------------------
`define CT_RST_ANALOG_GAIN 8'h00
`define CT_RST_VOLUME 8'hC9
`define CT_RST_GAIN_TRIM 8'h80
`define CT_RST_PHASE_TRIM 8'h00
`define CT_MASK_ANALOG_GAIN 8'hFC
`define CT_MASK_GAIN_TRIM 8'hF0
`define CT_GAIN_LSB 2
`define CT_TRIM_LSB 4

// ----------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------
`define CT_GAIN_MAX_CODE 6'h2A
`define CT_VOL_MUTE_CODE 8'h00
`define CT_VOL_UNITY_CODE 8'hC9
`define CT_TRIM_ZERO_CODE 4'h8
// Volume in half decibels relative to unity: code minus 201.
`define CT_VOL_UNITY_HALF_DB 9'h0C9

`endif

// >>> chan_trim_pkg.sv
// Types shared by the channel trim bank.
`default_nettype none
package chan_trim_pkg;

    // Source feeding channel 5.
    typedef enum logic [1:0] {
        SRC_ANALOG = 2'h1,
        SRC_DIGITAL_MIC = 2'h2
    } ch5_src_e;

    // State of the phase delay line per sample.
    typedef enum logic [1:0] {
        DLY_IDLE = 2'h1,
        DLY_COUNT = 2'h2
    } dly_state_e;

endpackage : chan_trim_pkg
`default_nettype wire

// >>> phase_delay.sv
// Phase delay timer counting modulator clock ticks before releasing a sample.
`timescale 1ns/100ps
`default_nettype none
`include "chan_trim_regs.svh"
module phase_delay (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic mod_tick_in,
    input wire logic start_in,
    input wire logic [7:0] delay_in,
    output logic fire_out
);

    chan_trim_pkg::dly_state_e state_r;
    chan_trim_pkg::dly_state_e state_nxt;
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic fire_r;
    logic fire_nxt;

    // Count down one per modulator tick; code zero fires at once.
    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        fire_nxt = 1'b0;
        case (state_r)
            chan_trim_pkg::DLY_IDLE: begin
                if (start_in) begin
                    if (delay_in == 8'h00) begin
                        fire_nxt = 1'b1;
                    end else begin
                        count_nxt = delay_in;
                        state_nxt = chan_trim_pkg::DLY_COUNT;
                    end
                end
            end
            chan_trim_pkg::DLY_COUNT: begin
                if (mod_tick_in) begin
                    count_nxt = count_r - 8'h01;
                    if (count_r == 8'h01) begin
                        fire_nxt = 1'b1;
                        state_nxt = chan_trim_pkg::DLY_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = chan_trim_pkg::DLY_IDLE;
            end
        endcase
    end

    // Register the timer state.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_r <= chan_trim_pkg::DLY_IDLE;
            count_r <= 8'h00;
            fire_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            fire_r <= fire_nxt;
        end
    end

    assign fire_out = fire_r;

endmodule : phase_delay
`default_nettype wire

// >>> chan_trim_bank.sv
// Channel 4 and channel 5 gain, volume and calibration register bank.
`timescale 1ns/100ps
`default_nettype none
`include "chan_trim_regs.svh"
module chan_trim_bank (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] page_in,
    input wire logic [7:0] addr_in,
    input wire logic wr_en_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_en_in,
    input wire logic ch5_digital_mic_in,
    input wire logic mod_tick_in,
    input wire logic ch4_sample_in,
    output logic [7:0] rd_data_out,
    output logic [5:0] ch4_analog_gain_code_out,
    output logic ch4_mute_out,
    output logic signed [8:0] ch4_volume_half_db_out,
    output logic signed [4:0] ch4_analog_gain_code_trim_tenth_db_out,
    output logic [7:0] ch4_phase_trim_code_out,
    output logic ch4_sample_delayed_out,
    output logic ch5_mute_out,
    output logic signed [8:0] ch5_volume_half_db_out,
    output logic signed [4:0] ch5_gain_trim_tenth_db_out
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Volume code to half decibels relative to unity.
    function automatic logic signed [8:0] vol_half_db(input logic [7:0] c);
        vol_half_db = $signed({1'b0, c}) - $signed(`CT_VOL_UNITY_HALF_DB);
    endfunction : vol_half_db

    // Gain trim code to tenths of a decibel relative to zero.
    function automatic logic signed [4:0] trim_tenth_db(input logic [3:0] c);
        trim_tenth_db = $signed({1'b0, c})
            - $signed({1'b0, `CT_TRIM_ZERO_CODE});
    endfunction : trim_tenth_db

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0] ch4_analog_gain_r, ch4_analog_gain_nxt;
    logic [7:0] ch4_volume_r, ch4_volume_nxt;
    logic [7:0] ch4_analog_gain_code_trim_r, ch4_analog_gain_code_trim_nxt;
    logic [7:0] ch4_phase_trim_r, ch4_phase_trim_nxt;
    logic [7:0] ch5_volume_r, ch5_volume_nxt;
    logic [7:0] ch5_gain_trim_r, ch5_gain_trim_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;
    logic page_hit;

    assign page_hit = (page_in == `CT_PAGE_ZERO);

    // Write decode; reserved bits are masked off on the way in.
    always_comb begin
        ch4_analog_gain_nxt = ch4_analog_gain_r;
        ch4_volume_nxt = ch4_volume_r;
        ch4_analog_gain_code_trim_nxt = ch4_analog_gain_code_trim_r;
        ch4_phase_trim_nxt = ch4_phase_trim_r;
        ch5_volume_nxt = ch5_volume_r;
        ch5_gain_trim_nxt = ch5_gain_trim_r;
        if (wr_en_in && page_hit) begin
            case (addr_in)
                `CT_OFS_CH4_ANALOG_GAIN: begin
                    ch4_analog_gain_nxt =
                        wr_data_in & `CT_MASK_ANALOG_GAIN;
                end
                `CT_OFS_CH4_VOLUME: begin
                    ch4_volume_nxt = wr_data_in;
                end
                `CT_OFS_CH4_ANALOG_GAIN_CODE_TRIM: begin
                    ch4_analog_gain_code_trim_nxt = wr_data_in & `CT_MASK_GAIN_TRIM;
                end
                `CT_OFS_CH4_PHASE_TRIM: begin
                    ch4_phase_trim_nxt = wr_data_in;
                end
                `CT_OFS_CH5_VOLUME: begin
                    ch5_volume_nxt = wr_data_in;
                end
                `CT_OFS_CH5_GAIN_TRIM: begin
                    ch5_gain_trim_nxt = wr_data_in & `CT_MASK_GAIN_TRIM;
                end
                default: begin
                    ch4_volume_nxt = ch4_volume_r;
                end
            endcase
        end
    end

    // Read mux; unknown offsets read zero.
    always_comb begin
        rd_data_nxt = rd_data_r;
        if (rd_en_in) begin
            rd_data_nxt = 8'h00;
            if (page_hit) begin
                case (addr_in)
                    `CT_OFS_CH4_ANALOG_GAIN: rd_data_nxt = ch4_analog_gain_r;
                    `CT_OFS_CH4_VOLUME: rd_data_nxt = ch4_volume_r;
                    `CT_OFS_CH4_ANALOG_GAIN_CODE_TRIM: rd_data_nxt = ch4_analog_gain_code_trim_r;
                    `CT_OFS_CH4_PHASE_TRIM: rd_data_nxt = ch4_phase_trim_r;
                    `CT_OFS_CH5_VOLUME: rd_data_nxt = ch5_volume_r;
                    `CT_OFS_CH5_GAIN_TRIM: rd_data_nxt = ch5_gain_trim_r;
                    default: rd_data_nxt = 8'h00;
                endcase
            end
        end
    end

    // Register the bank with its reset values.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ch4_analog_gain_r <= `CT_RST_ANALOG_GAIN;
            ch4_volume_r <= `CT_RST_VOLUME;
            ch4_analog_gain_code_trim_r <= `CT_RST_GAIN_TRIM;
            ch4_phase_trim_r <= `CT_RST_PHASE_TRIM;
            ch5_volume_r <= `CT_RST_VOLUME;
            ch5_gain_trim_r <= `CT_RST_GAIN_TRIM;
            rd_data_r <= 8'h00;
        end else begin
            ch4_analog_gain_r <= ch4_analog_gain_nxt;
            ch4_volume_r <= ch4_volume_nxt;
            ch4_analog_gain_code_trim_r <= ch4_analog_gain_code_trim_nxt;
            ch4_phase_trim_r <= ch4_phase_trim_nxt;
            ch5_volume_r <= ch5_volume_nxt;
            ch5_gain_trim_r <= ch5_gain_trim_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Decoded settings toward the signal path
    // ------------------------------------------------------------------
    logic [5:0] gain_code_r, gain_code_nxt;
    logic ch4_mute_r, ch4_mute_nxt;
    logic signed [8:0] ch4_vol_r, ch4_vol_nxt;
    logic signed [4:0] ch4_trim_r, ch4_trim_nxt;
    logic ch5_mute_r, ch5_mute_nxt;
    logic signed [8:0] ch5_vol_r, ch5_vol_nxt;
    logic signed [4:0] ch5_trim_r, ch5_trim_nxt;

    // Translate codes into gains; channel 5 volume needs a digital mic.
    always_comb begin
        gain_code_nxt = ch4_analog_gain_r[7:`CT_GAIN_LSB];
        ch4_mute_nxt = (ch4_volume_r == `CT_VOL_MUTE_CODE);
        ch4_vol_nxt = vol_half_db(ch4_volume_r);
        ch4_trim_nxt = trim_tenth_db(ch4_analog_gain_code_trim_r[7:`CT_TRIM_LSB]);
        ch5_trim_nxt = trim_tenth_db(ch5_gain_trim_r[7:`CT_TRIM_LSB]);
        if (ch5_digital_mic_in) begin
            ch5_mute_nxt = (ch5_volume_r == `CT_VOL_MUTE_CODE);
            ch5_vol_nxt = vol_half_db(ch5_volume_r);
        end else begin
            ch5_mute_nxt = 1'b0;
            ch5_vol_nxt = 9'sh000;
        end
    end

    // Register the decoded settings.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            gain_code_r <= 6'h00;
            ch4_mute_r <= 1'b0;
            ch4_vol_r <= 9'sh000;
            ch4_trim_r <= 5'sh00;
            ch5_mute_r <= 1'b0;
            ch5_vol_r <= 9'sh000;
            ch5_trim_r <= 5'sh00;
        end else begin
            gain_code_r <= gain_code_nxt;
            ch4_mute_r <= ch4_mute_nxt;
            ch4_vol_r <= ch4_vol_nxt;
            ch4_trim_r <= ch4_trim_nxt;
            ch5_mute_r <= ch5_mute_nxt;
            ch5_vol_r <= ch5_vol_nxt;
            ch5_trim_r <= ch5_trim_nxt;
        end
    end

    // Phase delay of channel 4 samples in modulator ticks.
    phase_delay u_phase_delay (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .mod_tick_in(mod_tick_in),
        .start_in(ch4_sample_in),
        .delay_in(ch4_phase_trim_r),
        .fire_out(ch4_sample_delayed_out)
    );

    assign rd_data_out = rd_data_r;
    assign ch4_analog_gain_code_out = gain_code_r;
    assign ch4_mute_out = ch4_mute_r;
    assign ch4_volume_half_db_out = ch4_vol_r;
    assign ch4_analog_gain_code_trim_tenth_db_out = ch4_trim_r;
    assign ch4_phase_trim_code_out = ch4_phase_trim_r;
    assign ch5_mute_out = ch5_mute_r;
    assign ch5_volume_half_db_out = ch5_vol_r;
    assign ch5_gain_trim_tenth_db_out = ch5_trim_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    gain_reserved_zero_a: assert property (
        ch4_analog_gain_r[1:0] == 2'h0)
        else $error("Reserved analog gain bits set.");
    trim_reserved_zero_a: assert property (
        (ch4_analog_gain_code_trim_r[3:0] == 4'h0) && (ch5_gain_trim_r[3:0] == 4'h0))
        else $error("Reserved gain trim bits set.");
    ch4_mute_a: assert property (
        ch4_volume_r == 8'h00 |=> ch4_mute_out)
        else $error("Zero volume did not mute.");
    vol_unity_a: assert property (
        ch4_volume_r == 8'hC9 |=> ch4_volume_half_db_out == 9'sh000)
        else $error("Unity code not at 0 dB.");
    vol_max_a: assert property (
        ch4_volume_r == 8'hFF |=> ch4_volume_half_db_out == 9'sh036)
        else $error("Top code not at +27 dB.");
    vol_min_a: assert property (
        ch4_volume_r == 8'h01 |=> ch4_volume_half_db_out == 9'sh138)
        else $error("Code one not at -100 dB.");
    trim_zero_a: assert property (
        ch4_analog_gain_code_trim_r[7:4] == 4'h8
        |=> ch4_analog_gain_code_trim_tenth_db_out == 5'sh00)
        else $error("Trim code 8 not at 0 dB.");
    vol_write_a: assert property (
        wr_en_in && page_in == 8'h00 && addr_in == 8'h4D
        |=> ch4_volume_r == $past(wr_data_in))
        else $error("Volume write lost.");
    gain_follow_a: assert property (
        wr_en_in && page_in == 8'h00 && addr_in == 8'h4C
        |-> ##2 ch4_analog_gain_code_out == $past(wr_data_in[7:2], 2))
        else $error("Analog gain code not applied.");
    ch5_inactive_a: assert property (
        !ch5_digital_mic_in |=> !ch5_mute_out)
        else $error("Channel 5 volume acted on analog source.");
    phase_zero_a: assert property (
        ch4_sample_in && ch4_phase_trim_r == 8'h00
        && u_phase_delay.state_r == chan_trim_pkg::DLY_IDLE
        |=> ch4_sample_delayed_out)
        else $error("Zero phase trim delayed.");

    mute_seen_c: cover property (ch4_mute_out);
    ch5_active_c: cover property (ch5_digital_mic_in && ch5_mute_out);
    delay_fire_c: cover property (ch4_sample_delayed_out && ch4_phase_trim_r != 8'h00);

endmodule : chan_trim_bank
`default_nettype wire

// >>> chan_trim_bank_tb_top.sv
// Self-checking testbench for the channel trim register bank.
`timescale 1ns/100ps
`default_nettype none
module chan_trim_bank_tb_top;
    logic sys_clk, rst, wr_en, rd_en, mic, tick, sample;
    logic [7:0] page, addr, wr_data, rd_data, phase_code;
    logic [5:0] gain_code;
    logic ch4_mute, ch4_dly, ch5_mute;
    logic signed [8:0] ch4_vol, ch5_vol;
    logic signed [4:0] ch4_trim, ch5_trim;
    logic [7:0] model [0:5];
    logic [7:0] offs [0:5] = '{8'h4C, 8'h4D, 8'h4E, 8'h4F, 8'h52, 8'h53};
    logic [7:0] rstv [0:5] = '{8'h00, 8'hC9, 8'h80, 8'h00, 8'hC9, 8'h80};
    logic [7:0] vcodes [0:5] = '{8'h00, 8'h01, 8'h02, 8'hC9, 8'hFE, 8'hFF};
    logic [15:0] seed = 16'h0FDE;
    int miscompares = 0;
    int check_count = 0;

    chan_trim_bank dut (
        .sys_clk_in(sys_clk),
        .rst_in(rst),
        .page_in(page),
        .addr_in(addr),
        .wr_en_in(wr_en),
        .wr_data_in(wr_data),
        .rd_en_in(rd_en),
        .ch5_digital_mic_in(mic),
        .mod_tick_in(tick),
        .ch4_sample_in(sample),
        .rd_data_out(rd_data),
        .ch4_analog_gain_code_out(gain_code),
        .ch4_mute_out(ch4_mute),
        .ch4_volume_half_db_out(ch4_vol),
        .ch4_analog_gain_code_trim_tenth_db_out(ch4_trim),
        .ch4_phase_trim_code_out(phase_code),
        .ch4_sample_delayed_out(ch4_dly),
        .ch5_mute_out(ch5_mute),
        .ch5_volume_half_db_out(ch5_vol),
        .ch5_gain_trim_tenth_db_out(ch5_trim)
    );

    // ----------------------------------------------------------------
    // Expectation helpers
    // ----------------------------------------------------------------
    // Galois shift register that supplies the random stimulus.
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
    endfunction : lfsr

    // Writable bits of each register; the rest always read zero.
    function automatic logic [7:0] wmask(input int i);
        return (i == 0) ? 8'hFC : ((i == 2 || i == 5) ? 8'hF0 : 8'hFF);
    endfunction : wmask

    // Volume in half decibels with code 201 as unity.
    function automatic logic signed [8:0] exp_vol(input logic [7:0] c);
        return $signed({1'b0, c}) - 9'sh0C9;
    endfunction : exp_vol

    // Trim in tenths of a decibel with code 8 as zero.
    function automatic logic signed [4:0] exp_trim(input logic [3:0] c);
        return $signed({1'b0, c}) - 5'sh08;
    endfunction : exp_trim

    // ----------------------------------------------------------------
    // Bus and comparison tasks
    // ----------------------------------------------------------------
    // Counts a comparison and reports a mismatch at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // One write strobe, taken at the second edge.
    task automatic wr(input logic [7:0] pg, input logic [7:0] a,
                      input logic [7:0] d);
        @(posedge sys_clk);
        page <= pg;
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask : wr

    // One read strobe; data is sampled a cycle after it is taken.
    task automatic rd(input logic [7:0] pg, input logic [7:0] a,
                      output logic [7:0] d);
        @(posedge sys_clk);
        page <= pg;
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        @(posedge sys_clk);
        #1;
        d = rd_data;
    endtask : rd

    // Reads every register back and compares it with the model.
    task automatic check_regs();
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            rd(8'h00, offs[i], d);
            check(d, model[i]);
        end
    endtask : check_regs

    // Compares the decoded outputs two edges after the last write.
    task automatic check_decode();
        repeat (2) @(posedge sys_clk);
        #1;
        check(gain_code, model[0][7:2]);
        check(ch4_mute, model[1] == 8'h00);
        if (model[1] != 8'h00) check(ch4_vol, exp_vol(model[1]));
        check(ch4_trim, exp_trim(model[2][7:4]));
        check(phase_code, model[3]);
        check(ch5_mute, mic && model[4] == 8'h00);
        if (!mic) check(ch5_vol, 9'sh000);
        else if (model[4] != 8'h00) check(ch5_vol, exp_vol(model[4]));
        check(ch5_trim, exp_trim(model[5][7:4]));
    endtask : check_decode

    // Writes a register through the bus and updates the model.
    task automatic put(input int i, input logic [7:0] d);
        wr(8'h00, offs[i], d);
        model[i] = d & wmask(i);
    endtask : put

    // Starts a sample, ticks the modulator every other cycle, retries a
    // start while counting, and checks the single release pulse.
    task automatic phase_run(input int n);
        @(posedge sys_clk);
        sample <= 1'b1;
        for (int k = 0; k <= 2 * n + 6; k++) begin
            @(posedge sys_clk);
            tick <= (k >= 2 && k % 2 == 0 && k <= 2 * n);
            sample <= (k == 1 && n > 0);
            #1;
            check(ch4_dly, k == ((n == 0) ? 0 : 2 * n + 1));
        end
    endtask : phase_run

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("miscompares %0d check_count %0d", miscompares, check_count);
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // ----------------------------------------------------------------
    // Clock and main sequence
    // ----------------------------------------------------------------
    // Free-running 20 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Reset, corner cases, random traffic, phase delay and a second reset.
    initial begin
        logic [7:0] d;
        int i;
        {rst, wr_en, rd_en, mic, tick, sample} = 6'h20;
        {page, addr, wr_data} = 24'h000000;
        for (int j = 0; j < 6; j++) model[j] = rstv[j];
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        check_regs();
        check_decode();
        for (int j = 0; j < 12; j++) begin
            put(1, vcodes[j % 6]);
            put(4, vcodes[j % 6]);
            mic <= j[0] ^ (j > 5);
            check_decode();
        end
        put(0, 8'hAB);
        put(2, 8'h0F);
        put(5, 8'hFF);
        check_regs();
        check_decode();
        repeat (60) begin
            seed = lfsr(seed);
            i = int'(seed[2:0]) % 6;
            d = (i == 0) ? {6'(seed[15:10] % 43), seed[9:8]}
                : seed[15:8];
            if (seed[5:3] == 3'h0) wr(8'h01, offs[i], d);
            else if (seed[5:3] == 3'h1) wr(8'h00, 8'h50, d);
            else put(i, d);
            mic <= seed[6];
            check_decode();
        end
        check_regs();
        rd(8'h00, 8'h50, d);
        check(d, 8'h00);
        rd(8'h01, 8'h4D, d);
        check(d, 8'h00);
        for (int j = 0; j < 5; j++) begin
            seed = lfsr(seed);
            d = (j < 3) ? 8'(j) : ((j == 3) ? 8'hFF : {5'h00, seed[2:0]});
            put(3, d);
            phase_run(int'(d));
        end
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        for (int j = 0; j < 6; j++) model[j] = rstv[j];
        check_regs();
        check_decode();
        summarize();
    end
endmodule : chan_trim_bank_tb_top
`default_nettype wire
